// *** pkg/dzc_pkg.sv ***
// Shared constants, types and timing for the calibration and power-down termination block
package dzc_pkg;

  // Clock rate
  localparam int unsigned CLK_PERIOD_PS = 25000;

  // Command encoding on the decoded command bus
  localparam logic [3:0] CMD_NOP       = 4'h0;
  localparam logic [3:0] CMD_REFRESH   = 4'h1;
  localparam logic [3:0] CMD_CAL       = 4'h2;
  localparam logic [3:0] CMD_SR_EXIT   = 4'h3;
  localparam logic [3:0] CMD_MODE_SET  = 4'h4;
  localparam int unsigned ADDR_LONG_BIT = 10;
  localparam int unsigned FREEZE_BIT_POS = 12;
  localparam logic        FREEZE_FROZEN = 1'b0;

  // Calibration windows, in clock cycles of the memory clock
  localparam int unsigned INIT_CAL_CYC  = 512;
  localparam int unsigned OPER_CAL_CYC  = 256;
  localparam int unsigned SHORT_CAL_CYC = 64;

  // Power-down related delays, in clock cycles
  localparam int unsigned CKE_LOW_DLY_CYC  = 1;
  localparam int unsigned REFRESH_CYC      = 104;
  localparam int unsigned PD_EXIT_DLL_CYC  = 10;

  // Termination delays, in picoseconds
  localparam int unsigned ASYNC_ON_MIN_PS  = 2000;
  localparam int unsigned ASYNC_ON_MAX_PS  = 8500;
  localparam int unsigned ASYNC_OFF_MIN_PS = 2000;
  localparam int unsigned ASYNC_OFF_MAX_PS = 8500;

  // Cycle counts derived from the rate; minimum rounds up, maximum rounds down to no less than one
  localparam int unsigned ASYNC_ON_MIN_CYC  =
    (ASYNC_ON_MIN_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned ASYNC_ON_MAX_RAW  = ASYNC_ON_MAX_PS / CLK_PERIOD_PS;
  localparam int unsigned ASYNC_ON_MAX_CYC  = (ASYNC_ON_MAX_RAW < 1) ? 1 : ASYNC_ON_MAX_RAW;
  localparam int unsigned ASYNC_OFF_MIN_CYC =
    (ASYNC_OFF_MIN_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned ASYNC_OFF_MAX_RAW = ASYNC_OFF_MAX_PS / CLK_PERIOD_PS;
  localparam int unsigned ASYNC_OFF_MAX_CYC =
    (ASYNC_OFF_MAX_RAW < 1) ? 1 : ASYNC_OFF_MAX_RAW;
  // Asynchronous delay the device applies
  localparam int unsigned ASYNC_TERM_CYC = ASYNC_ON_MIN_CYC;

  // Latency field defaults
  localparam logic [4:0] WRITE_LATENCY_RST = 5'h05;
  localparam logic [4:0] TERM_LAT_OFFSET   = 5'h02;
  localparam logic [4:0] LEAD_OFFSET       = 5'h01;

  // Counter width for the calibration, refresh, entry and exit windows
  localparam int unsigned CNT_W = 12;

  // Calibration state
  typedef enum logic [2:0] {
    DZC_CAL_IDLE  = 3'b001,
    DZC_CAL_RUN   = 3'b010,
    DZC_CAL_XFER  = 3'b100
  } dzc_cal_state_e;

  // Decoded command from the controller
  typedef struct packed {
    logic [3:0]  cmd;
    logic [15:0] addr;
  } dzc_cmd_s;

  // Calibration results handed to the I/O
  typedef struct packed {
    logic [5:0] drive_code;
    logic [5:0] term_code;
  } dzc_cal_code_s;

endpackage : dzc_pkg

// *** hw/dzc_down_counter.sv ***
// Loadable down counter with a busy flag
`timescale 1ns/1ps
`default_nettype none
module dzc_down_counter
  import dzc_pkg::*;
#(
  parameter int unsigned W = CNT_W
) (
  // Clock and reset
  input  wire logic         clock,
  input  wire logic         rst_n,
  // Control
  input  wire logic         load,
  input  wire logic [W-1:0] load_value,
  // State
  output logic              busy,
  output logic [W-1:0]      count
);

  logic [W-1:0] next_count;

  // Load wins over counting so a restart is never lost
  always_comb begin
    next_count = count;
    if (load) begin
      next_count = load_value;
    end else if (count != '0) begin
      next_count = count - W'(1);
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      count <= '0;
    end else begin
      count <= next_count;
    end
  end

  assign busy = (count != '0);

endmodule : dzc_down_counter
`default_nettype wire

// *** hw/dzc_delay_line.sv ***
// Shift line that delays the termination request by a selectable number of cycles
`timescale 1ns/1ps
`default_nettype none
module dzc_delay_line
  import dzc_pkg::*;
#(
  parameter int unsigned DEPTH = 32
) (
  // Clock and reset
  input  wire logic                     clock,
  input  wire logic                     rst_n,
  // Data
  input  wire logic                     din,
  input  wire logic [$clog2(DEPTH)-1:0] tap,
  // Delayed result
  output logic                          dout
);

  logic [DEPTH-1:0] line;
  logic [DEPTH-1:0] next_line;

  // Tap zero is the input registered once
  always_comb begin
    next_line = {line[DEPTH-2:0], din};
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      line <= '0;
    end else begin
      line <= next_line;
    end
  end

  assign dout = line[tap];

endmodule : dzc_delay_line
`default_nettype wire

// *** hw/dzc_cal_odt.sv ***
// Calibration command engine and power-down termination mode transition logic
`timescale 1ns/1ps
`default_nettype none
// Contract
// RL1: Transition behaviour only when DLL frozen
// RL2: Entry lead window is write latency minus one
// RL3: Entry period excludes start, includes end
// RL4: Pending refresh extends entry period end
// RL5: Entry turn-on within combined min/max
// RL6: Entry turn-off within combined min/max
// RL7: Exit period from lead to DLL exit delay
// RL8: Exit responses use same combined bounds
// RL9: Short power-down merges both periods
// RL10: Short idle merges exit and entry periods
// RL11: Long calibration runs engine, transfers codes
// RL12: First long gets initial time, later operational
// RL13: Short calibration finishes within short time
// RL14: Controller keeps channel quiet during calibration
// RL15: Calibration current path off when done
// RL16: Controller precharges all banks before calibration
// RL17: No calibration started after self-refresh exit
// RL18: Controller waits self-refresh exit delay
// RL19: Shared resistor calibrations never overlap
// RL20: Clock enable held high during calibration
// RL21: Termination off during calibration window
// RL22: Data pins high impedance during calibration
// RL23: Synchronous termination latency is write latency minus two; the code uses write latency plus additive latency minus two
// RL24: Asynchronous path ignores additive latency
// RL25: Address bit ten selects long or short
module dzc_cal_odt
  import dzc_pkg::*;
#(
  parameter int unsigned LAT_DEPTH = 32
) (
  // Clock and reset
  input  wire logic          clock,
  input  wire logic          arst_n,
  // Command side from the controller
  input  wire dzc_cmd_s      cmd_in,
  input  wire logic          cke,
  input  wire logic          odt,
  // Latency settings from mode registers
  input  wire logic [4:0]    write_latency,
  input  wire logic [4:0]    additive_latency,
  // Calibration engine result
  input  wire dzc_cal_code_s engine_code,
  // Calibration outputs
  output logic               cal_busy,
  output logic               cal_current_en,
  output dzc_cal_code_s      io_code,
  output logic               dq_hold_hiz,
  // Termination outputs
  output logic               term_on,
  output logic               term_async_mode,
  output logic               transition_active
);

  // Reset release through two flops
  logic rst_meta;
  logic rst_n;
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  // Calibration
  dzc_cal_state_e cal_state, next_cal_state;
  logic           first_long_done, next_first_long_done;
  logic           cal_load;
  logic [CNT_W-1:0] cal_len;
  logic [CNT_W-1:0] cal_cnt;
  dzc_cal_code_s  next_io_code;
  logic           next_cal_busy, next_cal_current_en, next_dq_hold_hiz;

  dzc_down_counter #(.W(CNT_W)) u_cal_cnt (
    .clock      (clock),
    .rst_n      (rst_n),
    .load       (cal_load),
    .load_value (cal_len),
    .busy       (),
    .count      (cal_cnt)
  );

  // Start only on explicit command; self-refresh exit never starts one [RL17]
  always_comb begin
    next_cal_state       = cal_state;
    next_first_long_done = first_long_done;
    next_io_code         = io_code;
    cal_load             = 1'b0;
    cal_len              = CNT_W'(SHORT_CAL_CYC);
    unique case (cal_state)
      DZC_CAL_IDLE: begin
        if (cmd_in.cmd == CMD_CAL) begin
          cal_load       = 1'b1;
          next_cal_state = DZC_CAL_RUN;
          if (cmd_in.addr[ADDR_LONG_BIT]) begin // [RL25]
            cal_len = first_long_done ? CNT_W'(OPER_CAL_CYC)
                                      : CNT_W'(INIT_CAL_CYC); // [RL12] [RL11]
            next_first_long_done = 1'b1;
          end else begin
            cal_len = CNT_W'(SHORT_CAL_CYC); // [RL13]
          end
        end
      end
      DZC_CAL_RUN: begin
        // Transfer one cycle before the window closes so codes land on the edge that closes it
        if (cal_cnt <= CNT_W'(2)) begin
          next_cal_state = DZC_CAL_XFER;
        end
      end
      DZC_CAL_XFER: begin
        next_io_code   = engine_code; // [RL11] [RL13]
        next_cal_state = DZC_CAL_IDLE;
      end
      default: next_cal_state = DZC_CAL_IDLE;
    endcase
    next_cal_busy       = (next_cal_state != DZC_CAL_IDLE);
    next_cal_current_en = (next_cal_state == DZC_CAL_RUN); // [RL15]
    next_dq_hold_hiz    = next_cal_busy; // [RL22]
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cal_state       <= DZC_CAL_IDLE;
      first_long_done <= 1'b0;
      io_code         <= '0;
      cal_busy        <= 1'b0;
      cal_current_en  <= 1'b0;
      dq_hold_hiz     <= 1'b0;
    end else begin
      cal_state       <= next_cal_state;
      first_long_done <= next_first_long_done;
      io_code         <= next_io_code;
      cal_busy        <= next_cal_busy;
      cal_current_en  <= next_cal_current_en;
      dq_hold_hiz     <= next_dq_hold_hiz;
    end
  end

  // Mode register freeze bit
  logic dll_frozen, next_dll_frozen;
  always_comb begin
    next_dll_frozen = dll_frozen;
    if (cmd_in.cmd == CMD_MODE_SET) begin
      next_dll_frozen = (cmd_in.addr[FREEZE_BIT_POS] == FREEZE_FROZEN);
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      dll_frozen <= 1'b0;
    end else begin
      dll_frozen <= next_dll_frozen;
    end
  end

  // Power-down transition periods
  // The lead window looks backwards, so the device holds the period open
  // for the lead length after each clock enable edge in frozen mode instead of predicting it.
  logic cke_q, next_cke_q;
  logic cke_fall, cke_rise;
  logic [CNT_W-1:0] entry_len, exit_len, ref_rem;
  logic entry_load, exit_load;
  logic entry_busy, exit_busy, ref_busy;
  logic [CNT_W-1:0] ref_cnt;
  logic lead_open, next_lead_open;
  logic [4:0] lead_cnt, next_lead_cnt;
  logic [4:0] lead_len;

  assign cke_fall = cke_q & ~cke;
  assign cke_rise = ~cke_q & cke;
  assign lead_len = write_latency - LEAD_OFFSET; // [RL2]

  dzc_down_counter #(.W(CNT_W)) u_ref_cnt (
    .clock      (clock),
    .rst_n      (rst_n),
    .load       (cmd_in.cmd == CMD_REFRESH),
    .load_value (CNT_W'(REFRESH_CYC)),
    .busy       (ref_busy),
    .count      (ref_cnt)
  );

  // Entry period end is the later of the low delay and the refresh remainder
  always_comb begin
    ref_rem    = ref_busy ? ref_cnt : CNT_W'(0);
    entry_len  = (ref_rem > CNT_W'(CKE_LOW_DLY_CYC)) ? ref_rem
                                                     : CNT_W'(CKE_LOW_DLY_CYC); // [RL4] [RL3]
    entry_load = cke_fall & dll_frozen; // [RL1]
    exit_len   = CNT_W'(PD_EXIT_DLL_CYC); // [RL7]
    exit_load  = cke_rise & dll_frozen; // [RL1]
  end

  dzc_down_counter #(.W(CNT_W)) u_entry_cnt (
    .clock      (clock),
    .rst_n      (rst_n),
    .load       (entry_load),
    .load_value (entry_len),
    .busy       (entry_busy),
    .count      ()
  );

  dzc_down_counter #(.W(CNT_W)) u_exit_cnt (
    .clock      (clock),
    .rst_n      (rst_n),
    .load       (exit_load),
    .load_value (exit_len),
    .busy       (exit_busy),
    .count      ()
  );

  // Lead window: the last write_latency-1 cycles before a clock enable edge
  // are covered by holding the period open that long after a possible edge;
  // a bounded look-back is cheaper than predicting the controller.
  always_comb begin
    next_cke_q     = cke;
    next_lead_open = lead_open;
    next_lead_cnt  = lead_cnt;
    if (lead_cnt != 5'h00) begin
      next_lead_cnt = lead_cnt - 5'h01;
    end else begin
      next_lead_open = 1'b0;
    end
    if ((cke_fall | cke_rise) & dll_frozen) begin
      next_lead_open = 1'b1;
      next_lead_cnt  = lead_len; // [RL2] [RL7]
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cke_q     <= 1'b1;
      lead_open <= 1'b0;
      lead_cnt  <= 5'h00;
    end else begin
      cke_q     <= next_cke_q;
      lead_open <= next_lead_open;
      lead_cnt  <= next_lead_cnt;
    end
  end

  // Overlapping periods merge into one continuous uncertain stretch
  logic in_pd, next_in_pd;
  logic next_transition, next_async;
  always_comb begin
    next_in_pd      = in_pd;
    if (cke_fall) begin
      next_in_pd = 1'b1;
    end else if (cke_rise) begin
      next_in_pd = 1'b0;
    end
    next_transition = dll_frozen &
                      (entry_load | exit_load | entry_busy | exit_busy | lead_open); // [RL9] [RL10] [RL3]
    // Inside a transition the device picks the asynchronous path, a legal choice
    next_async = dll_frozen & (next_in_pd | next_transition); // [RL8] [RL5] [RL6]
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      in_pd             <= 1'b0;
      transition_active <= 1'b0;
      term_async_mode   <= 1'b0;
    end else begin
      in_pd             <= next_in_pd;
      transition_active <= next_transition;
      term_async_mode   <= next_async;
    end
  end

  // Termination timing
  localparam int unsigned TAP_W = $clog2(LAT_DEPTH);
  logic [TAP_W-1:0] sync_tap, async_tap;
  logic             sync_term, async_term;
  logic [4:0]       sync_lat;

  // Synchronous: write latency plus additive latency, minus two
  always_comb begin
    sync_lat  = write_latency + additive_latency - TERM_LAT_OFFSET; // [RL23]
    sync_tap  = (sync_lat == 5'h00) ? TAP_W'(0) : TAP_W'(sync_lat - 5'h01);
    async_tap = TAP_W'(ASYNC_TERM_CYC - 1); // [RL24]
  end

  dzc_delay_line #(.DEPTH(LAT_DEPTH)) u_sync_line (
    .clock (clock),
    .rst_n (rst_n),
    .din   (odt),
    .tap   (sync_tap),
    .dout  (sync_term)
  );

  dzc_delay_line #(.DEPTH(LAT_DEPTH)) u_async_line (
    .clock (clock),
    .rst_n (rst_n),
    .din   (odt),
    .tap   (async_tap),
    .dout  (async_term)
  );

  // Termination forced off from the take edge on; a safety net only
  logic next_term_on;
  always_comb begin
    next_term_on = (term_async_mode ? async_term : sync_term) // [RL5] [RL6]
                   & ~cal_busy & ~next_cal_busy;
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      term_on <= 1'b0;
    end else begin
      term_on <= next_term_on;
    end
  end

endmodule : dzc_cal_odt
`default_nettype wire

// *** verif/dzc_cal_odt_chk.sv ***
// Port checker for the calibration and power-down termination block
`timescale 1ns/1ps
`default_nettype none
module dzc_cal_odt_chk
  import dzc_pkg::*;
(
  // Clock and reset
  input wire logic          clock,
  input wire logic          arst_n,
  // Controller side
  input wire dzc_cmd_s      cmd_in,
  input wire logic          cke,
  input wire dzc_cal_code_s engine_code,
  // Outputs under watch
  input wire logic          cal_busy,
  input wire logic          cal_current_en,
  input wire dzc_cal_code_s io_code,
  input wire logic          dq_hold_hiz,
  input wire logic          term_on,
  input wire logic          term_async_mode,
  input wire logic          transition_active
);
  logic [1:0]       rdy_cnt;
  logic [CNT_W-1:0] busy_cnt;
  logic [CNT_W-1:0] win;
  logic             long_done;
  logic             frozen;
  logic             take;
  assign take = (rdy_cnt == 2'h3) && !cal_busy && (cmd_in.cmd == CMD_CAL);
  // Model of window length and freeze mode; reset settle counted first
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      rdy_cnt <= 2'h0;
      busy_cnt <= '0;
      win <= '0;
      long_done <= 1'b0;
      frozen <= 1'b0;
    end else begin
      rdy_cnt <= (rdy_cnt == 2'h3) ? rdy_cnt : rdy_cnt + 2'h1;
      busy_cnt <= cal_busy ? busy_cnt + 1'b1 : '0;
      if (take) begin
        win <= !cmd_in.addr[10] ? CNT_W'(SHORT_CAL_CYC) :
               (long_done ? CNT_W'(OPER_CAL_CYC) : CNT_W'(INIT_CAL_CYC));
        long_done <= long_done | cmd_in.addr[10];
      end
      if ((rdy_cnt == 2'h3) && (cmd_in.cmd == CMD_MODE_SET)) begin
        frozen <= (cmd_in.addr[12] == FREEZE_FROZEN);
      end
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);
  hiz_follow_a: assert property (dq_hold_hiz == cal_busy)
    else $error("data hold flag differs from busy");
  cal_take_a: assert property (take && !$past(cal_busy) |=> cal_busy)
    else $error("calibration command not taken");
  cal_len_a: assert property ($fell(cal_busy) |-> busy_cnt <= win && busy_cnt + 2 >= win)
    else $error("calibration window length wrong");
  no_self_cal_a: assert property (!cal_busy && cmd_in.cmd != CMD_CAL |=> !cal_busy)
    else $error("calibration started without command");
  current_off_a: assert property ($fell(cal_current_en) |-> ##[0:1] !cal_busy)
    else $error("window outlasts calibration current");
  code_hold_a: assert property (!cal_busy && !$past(cal_busy) |-> $stable(io_code))
    else $error("codes moved outside calibration");
  code_xfer_a: assert property ($fell(cal_busy) |-> io_code == engine_code)
    else $error("codes not transferred");
  term_quiet_a: assert property (cal_busy |-> !term_on)
    else $error("termination on during calibration");
  trans_async_a: assert property (transition_active |-> term_async_mode)
    else $error("transition without async response");
  entry_open_a: assert property (frozen && $fell(cke) |-> ##[1:2] transition_active)
    else $error("entry transition not opened");
  unfrozen_a: assert property (!frozen && !transition_active && $fell(cke)
    |=> !transition_active ##1 !transition_active)
    else $error("transition without frozen mode");
  exit_span_a: assert property (frozen && $rose(cke) |-> ##2 transition_active [*8])
    else $error("exit transition too short");
endmodule : dzc_cal_odt_chk
bind dzc_cal_odt dzc_cal_odt_chk i_dzc_cal_odt_chk (.clock(clock), .arst_n(arst_n),
  .cmd_in(cmd_in), .cke(cke), .engine_code(engine_code), .cal_busy(cal_busy),
  .cal_current_en(cal_current_en), .io_code(io_code), .dq_hold_hiz(dq_hold_hiz),
  .term_on(term_on), .term_async_mode(term_async_mode),
  .transition_active(transition_active));
`default_nettype wire

// *** verif/dzc_ctrl_model.sv ***
// Memory controller model driving commands, clock enable and termination request
`timescale 1ns/1ps
`default_nettype none
module dzc_ctrl_model
  import dzc_pkg::*;
#(
  parameter int unsigned SR_EXIT_DLY = 16
) (
  // Clock and status
  input  wire logic     clock,
  input  wire logic     cal_busy,
  // Controller pins
  output var  dzc_cmd_s cmd_in,
  output var  logic     cke,
  output var  logic     odt
);
  initial begin
    cmd_in = '0;
    cke = 1'b1;
    odt = 1'b0;
  end
  // One command cycle; idle address scrambled so stale values never look valid
  task automatic issue(input logic [3:0] c, input logic [15:0] a);
    @(negedge clock);
    cmd_in <= '{cmd: c, addr: a};
    @(negedge clock);
    cmd_in <= '{cmd: CMD_NOP, addr: ~a};
  endtask : issue
  // Pin levels change only after a falling edge
  task automatic pins(input logic k, input logic o);
    @(negedge clock);
    cke <= k;
    odt <= o;
  endtask : pins
  // Banks assumed closed; a second command only when a scenario asks for it
  task automatic calibrate(input logic lng, input logic intrude);
    int n;
    pins(1'b1, 1'b0);
    issue(CMD_CAL, {5'h00, lng, 10'h000});
    if (intrude) issue(CMD_CAL, 16'h0400);
    n = 0;
    while (cal_busy && n < 1000) begin
      @(negedge clock);
      n++;
    end
  endtask : calibrate
  // Nothing but idle until the exit delay has run out
  task automatic leave_self_refresh();
    issue(CMD_SR_EXIT, 16'h0400);
    repeat (SR_EXIT_DLY) @(negedge clock);
  endtask : leave_self_refresh
endmodule : dzc_ctrl_model
`default_nettype wire

// *** verif/dzc_cal_odt_tb_top.sv ***
// Self-checking bench for the calibration and power-down termination block
`timescale 1ns/1ps
`default_nettype none
module dzc_cal_odt_tb_top;
  import dzc_pkg::*;
  typedef struct { int len; dzc_cal_code_s code; } dzc_note_s;
  logic          clock, arst_n, cal_busy, cal_current_en, dq_hold_hiz;
  logic          cke, odt, term_on, term_async_mode, transition_active;
  logic [4:0]    wr_lat, add_lat;
  dzc_cmd_s      cmd_in;
  dzc_cal_code_s code, io_code;
  dzc_note_s     exp_q[$];
  int            lat_q[$];
  int            fails, checks, seed, i;
  dzc_cal_odt #(.LAT_DEPTH(32)) i_dzc_cal_odt (.clock(clock), .arst_n(arst_n),
    .cmd_in(cmd_in), .cke(cke), .odt(odt), .write_latency(wr_lat), .additive_latency(add_lat),
    .engine_code(code), .cal_busy(cal_busy), .cal_current_en(cal_current_en),
    .io_code(io_code), .dq_hold_hiz(dq_hold_hiz), .term_on(term_on),
    .term_async_mode(term_async_mode), .transition_active(transition_active));
  dzc_ctrl_model i_dzc_ctrl_model (.clock(clock), .cal_busy(cal_busy), .cmd_in(cmd_in),
    .cke(cke), .odt(odt));
  // 25 ns clock
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] expv);
    checks++;
    if (seen !== expv) begin
      fails++;
      $display("CHECK FAILED t=%0t seen %0h expected %0h", $time, seen, expv);
    end
  endtask : chk
  task automatic report_and_stop();
    $display("fails=%0d checks=%0d", fails, checks);
    if (fails == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : report_and_stop
  // Watcher: window length, transferred codes and termination latency
  initial begin : mon
    int n, t, u, lat;
    logic odt_q, on_q;
    dzc_note_s nt;
    n = 0;
    t = -1;
    u = -1;
    lat = 0;
    odt_q = 1'b0;
    on_q = 1'b0;
    forever begin
      @(posedge clock);
      #1;
      if (cal_busy === 1'b1) n++;
      else if (n != 0 && exp_q.size() > 0) begin
        nt = exp_q.pop_front();
        chk(n >= nt.len - 1 && n <= nt.len, 1);
        chk(io_code, nt.code);
        n = 0;
      end
      if (odt && !odt_q) t = 0;
      else if (t >= 0) t++;
      if (!odt && odt_q) u = 0;
      else if (u >= 0) u++;
      // Turn-on and turn-off share the latency noted for the request
      if (term_on === 1'b1 && !on_q && t >= 0 && lat_q.size() > 0) begin
        lat = lat_q.pop_front();
        chk(t, lat);
        t = -1;
      end
      if (term_on === 1'b0 && on_q && u >= 0) begin
        chk(u, lat);
        u = -1;
      end
      odt_q = odt;
      on_q = term_on;
    end
  end
  // Hang guard
  initial begin
    repeat (20000) @(posedge clock);
    fails++;
    report_and_stop();
  end
  initial begin
    seed = $urandom(32'h574955d4);
    arst_n = 1'b0;
    wr_lat = WRITE_LATENCY_RST;
    add_lat = 5'h00;
    code = '0;
    repeat (6) @(posedge clock);
    @(negedge clock) arst_n = 1'b1;
    repeat (5) @(negedge clock);
    // Long, long, short with a refused command inside the window, then short after self-refresh exit
    for (i = 0; i < 4; i++) begin
      if (i == 3) i_dzc_ctrl_model.leave_self_refresh();
      chk(cal_busy, 1'b0);
      @(negedge clock) code = 12'($urandom);
      exp_q.push_back('{len: (i == 0) ? INIT_CAL_CYC : (i == 1) ? OPER_CAL_CYC :
                        SHORT_CAL_CYC, code: code});
      i_dzc_ctrl_model.calibrate(i < 2, i == 2);
      repeat (4) @(negedge clock);
    end
    // Reset in mid-run: the next long calibration counts as the first again
    arst_n = 1'b0;
    repeat (2) @(negedge clock);
    arst_n = 1'b1;
    repeat (5) @(negedge clock);
    exp_q.push_back('{len: INIT_CAL_CYC, code: code});
    i_dzc_ctrl_model.calibrate(1'b1, 1'b0);
    repeat (4) @(negedge clock);
    // Synchronous termination at random latencies
    for (i = 0; i < 3; i++) begin
      @(negedge clock);
      wr_lat = 5'($urandom_range(5, 10));
      add_lat = 5'($urandom_range(0, 2));
      lat_q.push_back(int'(wr_lat) + int'(add_lat) - int'(TERM_LAT_OFFSET));
      i_dzc_ctrl_model.pins(1'b1, 1'b1);
      repeat (16) @(negedge clock);
      i_dzc_ctrl_model.pins(1'b1, 1'b0);
      repeat (16) @(negedge clock);
    end
    // Power-down without and with frozen mode, then a very short one
    i_dzc_ctrl_model.issue(CMD_MODE_SET, 16'h1000);
    i_dzc_ctrl_model.pins(1'b0, 1'b0);
    repeat (3) @(negedge clock);
    chk(transition_active, 1'b0);
    i_dzc_ctrl_model.pins(1'b1, 1'b0);
    repeat (20) @(negedge clock);
    i_dzc_ctrl_model.issue(CMD_MODE_SET, 16'h0000);
    i_dzc_ctrl_model.pins(1'b0, 1'b0);
    repeat (2) @(negedge clock);
    chk(transition_active, 1'b1);
    repeat (30) @(negedge clock);
    // Asynchronous response inside power-down, additive latency ignored
    lat_q.push_back(int'(ASYNC_ON_MIN_CYC));
    i_dzc_ctrl_model.pins(1'b0, 1'b1);
    repeat (8) @(negedge clock);
    i_dzc_ctrl_model.pins(1'b0, 1'b0);
    repeat (4) @(negedge clock);
    chk(term_async_mode, 1'b1);
    i_dzc_ctrl_model.pins(1'b1, 1'b0);
    repeat (2) @(negedge clock);
    chk(transition_active, 1'b1);
    repeat (PD_EXIT_DLL_CYC + 12) @(negedge clock);
    chk(transition_active, 1'b0);
    i_dzc_ctrl_model.pins(1'b0, 1'b0);
    i_dzc_ctrl_model.pins(1'b1, 1'b0);
    repeat (3) @(negedge clock);
    chk(transition_active, 1'b1);
    chk(term_async_mode, 1'b1);
    repeat (30) @(negedge clock);
    // Refresh still running at entry stretches the entry period
    i_dzc_ctrl_model.issue(CMD_REFRESH, 16'h0000);
    i_dzc_ctrl_model.pins(1'b0, 1'b0);
    repeat (REFRESH_CYC - 10) @(negedge clock);
    chk(transition_active, 1'b1);
    repeat (20) @(negedge clock);
    chk(transition_active, 1'b0);
    i_dzc_ctrl_model.pins(1'b1, 1'b0);
    repeat (30) @(negedge clock);
    chk(exp_q.size() + lat_q.size(), 0);
    report_and_stop();
  end
endmodule : dzc_cal_odt_tb_top
`default_nettype wire
